// ---- fag_defs.svh ----
// Offsets, field positions, reset values and flash map constants of the flash access guard
`ifndef FAG_DEFS_SVH
`define FAG_DEFS_SVH

// Register byte offsets on APB
`define FAG_OFS_CONTROL 12'h000
`define FAG_OFS_KEY 12'h004
`define FAG_OFS_LOCK 12'h008
`define FAG_OFS_STATUS 12'h00C

// Control register fields
`define FAG_CTL_WE_BIT 0
`define FAG_CTL_EE_BIT 1
`define FAG_CTL_RESET 2'h0

// Key codes
`define FAG_KEY_FIRST 8'hA5
`define FAG_KEY_SECOND 8'hF1

// Flash map: 8 KB in 512-byte pages
`define FAG_PAGE_MSB 12
`define FAG_PAGE_LSB 9
`define FAG_LOCK_ADDR 13'h1DFF
`define FAG_LOCK_PAGE 4'hE
`define FAG_RESERVED_PAGE 4'hF
`define FAG_LOCK_ERASED 8'hFF
`define FAG_PAGE_OFS_ZERO 9'h000

// Cause codes held in the status register
`define FAG_CAUSE_NONE 3'h0
`define FAG_CAUSE_RESERVED 3'h1
`define FAG_CAUSE_LOCKED 3'h2
`define FAG_CAUSE_ENABLE 3'h3
`define FAG_CAUSE_KEY 3'h4
`define FAG_CAUSE_LOCKBYTE 3'h5
`define FAG_CAUSE_SOURCE 3'h6

`endif

// ---- fag_flash_model.sv ----
// Behavioural flash holding the stored lock byte
`timescale 1ns/1ns
`include "fag_defs.svh"
module fag_flash_model (
  // Clock
  input wire logic pclk,
  // Granted commands and stored lock byte
  input wire fag_pkg::fag_cmd_t flash_cmd,
  output logic [7:0] lock_byte
);
  import fag_pkg::*;
  // Flash keeps its contents through reset
  logic [7:0] lock_reg = `FAG_LOCK_ERASED;
  wire logic go = flash_cmd.valid;
  assign lock_byte = lock_reg;
  always @(posedge pclk) begin
    if (go && flash_cmd.op == FAG_OP_WRITE && flash_cmd.addr == `FAG_LOCK_ADDR) begin
      lock_reg <= lock_reg & flash_cmd.wdata;
    end
    if (go && (flash_cmd.op == FAG_OP_ERASE_ALL || (flash_cmd.op == FAG_OP_ERASE &&
        flash_cmd.addr[12:9] == `FAG_LOCK_PAGE))) begin
      lock_reg <= `FAG_LOCK_ERASED;
    end
  end
endmodule

// ---- fag_guard.sv ----
// Flash access guard: APB registers, key sequencer and access decisions
//
// Notes on behaviour
// - Firmware modification needs write enable set
// - Firmware erase needs erase and write enable
// - Lock bits 7..4 low block debug writes
// - Lock bits 3..0 low block debug everything but whole-array erase
// - Lock bits readable always by firmware and APB, clearable only while no lock is set
// - Decisions use lock byte stored in flash
// - Only debug whole-array erase removes locks
// - Debug accesses unlocked pages, never locked ones
// - Debug reads lock byte only when unlocked
// - Locking further pages is rejected everywhere
// - Whole-array erase clears every page and lock
// - Reserved region never accessible
// - Unlocked firmware touching locked areas resets
// - Firmware erase of lock page resets
// - Unlocked firmware uses lock page if unlocked
// - Locked firmware reaches all pages, lock page read/write
// - Firmware may always read lock byte
// - Firmware cannot turn lock zeros into ones
// - Write enable steers data writes to flash
// - Two keys in order before each modification
// - Page erase covers whole 512-byte page
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "fag_defs.svh"

module fag_guard (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Access requests from debug port and firmware
  input wire fag_pkg::fag_req_t req,
  // Stored lock byte as read from flash
  input wire logic [7:0] lock_byte,
  // Granted command towards the flash array
  output fag_pkg::fag_cmd_t flash_cmd,
  output logic req_denied,
  output logic flash_error_reset,
  output logic xdata_to_flash
);
  import fag_pkg::*;

  fag_state_t st_reg;
  fag_state_t st_next;

  // Pages below the complement of the lock byte are locked, plus the lock page itself unless the lock byte is erased
  function automatic logic page_locked(input logic [3:0] page, input logic [7:0] lock);
    logic [7:0] count;
    count = ~lock;
    page_locked = (lock != `FAG_LOCK_ERASED) && (({4'h0, page} < count) || (page == `FAG_LOCK_PAGE));
  endfunction

  logic [3:0] page;
  logic [3:0] exec_page;
  logic is_reserved;
  logic is_lock_page;
  logic is_lock_byte;
  logic tgt_locked;
  logic exec_locked;
  logic any_lock;
  logic write_lock;
  logic rw_lock;
  logic key_hit;
  logic apb_setup;
  logic apb_write;

  always_comb begin
    page = req.addr[`FAG_PAGE_MSB:`FAG_PAGE_LSB];
    exec_page = req.exec_addr[`FAG_PAGE_MSB:`FAG_PAGE_LSB];
    is_reserved = (page == `FAG_RESERVED_PAGE);
    is_lock_page = (page == `FAG_LOCK_PAGE);
    is_lock_byte = (req.addr == `FAG_LOCK_ADDR);
    tgt_locked = page_locked(page, lock_byte);
    exec_locked = page_locked(exec_page, lock_byte);
    any_lock = (lock_byte != `FAG_LOCK_ERASED);
    write_lock = ~&lock_byte[7:4];
    rw_lock = ~&lock_byte[3:0];
    apb_setup = psel && !penable;
    apb_write = psel && penable && pwrite && st_reg.pready;
    key_hit = apb_write && (paddr == `FAG_OFS_KEY);
  end

  always_comb begin
    logic allow;
    logic fault;
    logic modify;
    logic [2:0] cause;
    allow = 1'b0;
    fault = 1'b0;
    modify = 1'b0;
    cause = `FAG_CAUSE_NONE;
    st_next = st_reg;
    st_next.cmd.valid = 1'b0;
    st_next.denied = 1'b0;
    st_next.flash_error = 1'b0;

    // Zero-wait APB: read data and error are latched in setup, pready rises for the access phase
    st_next.pready = apb_setup;
    if (apb_setup) begin
      st_next.pslverr = 1'b0;
      case (paddr)
        `FAG_OFS_CONTROL: st_next.prdata = {30'h0, st_reg.ctl};
        `FAG_OFS_KEY: st_next.prdata = {30'h0, st_reg.key};
        `FAG_OFS_LOCK: st_next.prdata = {24'h0, lock_byte};
        `FAG_OFS_STATUS: st_next.prdata = {21'h0, st_reg.cause, st_reg.deny_count};
        default: begin
          st_next.prdata = 32'h0;
          st_next.pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable) begin
      st_next.pready = 1'b0;
    end
    if (apb_write && (paddr == `FAG_OFS_CONTROL)) begin
      st_next.ctl = pwdata[1:0];
    end

    // Key sequencer: any wrong or misordered key kills modification until reset
    if (key_hit) begin
      case (st_reg.key)
        FAG_KEY_IDLE: st_next.key = (pwdata[7:0] == `FAG_KEY_FIRST) ? FAG_KEY_HALF : FAG_KEY_DEAD;
        FAG_KEY_HALF: st_next.key = (pwdata[7:0] == `FAG_KEY_SECOND) ? FAG_KEY_ARMED : FAG_KEY_DEAD;
        FAG_KEY_ARMED: st_next.key = FAG_KEY_DEAD;
        default: st_next.key = FAG_KEY_DEAD;
      endcase
    end

    if (req.valid) begin
      if (req.from_debug) begin
        case (req.op)
          FAG_OP_ERASE_ALL: allow = 1'b1;
          FAG_OP_READ: begin
            if (is_reserved) begin
              cause = `FAG_CAUSE_RESERVED;
            end else if (is_lock_byte) begin
              allow = !any_lock;
              cause = `FAG_CAUSE_LOCKBYTE;
            end else if (rw_lock || tgt_locked) begin
              cause = `FAG_CAUSE_LOCKED;
            end else begin
              allow = 1'b1;
            end
          end
          default: begin
            if (is_reserved) begin
              cause = `FAG_CAUSE_RESERVED;
            end else if (write_lock || rw_lock || tgt_locked) begin
              cause = `FAG_CAUSE_LOCKED;
            end else begin
              allow = 1'b1; // lock byte only writable while no lock is set
            end
          end
        endcase
      end else begin
        modify = (req.op == FAG_OP_WRITE) || (req.op == FAG_OP_ERASE);
        if (req.op == FAG_OP_ERASE_ALL) begin
          cause = `FAG_CAUSE_SOURCE;
        end else if (is_reserved) begin
          fault = 1'b1;
          cause = `FAG_CAUSE_RESERVED;
        end else if (req.op == FAG_OP_ERASE && is_lock_page) begin
          fault = 1'b1;
          cause = `FAG_CAUSE_LOCKBYTE;
        end else if (req.op == FAG_OP_READ && is_lock_byte) begin
          allow = 1'b1;
        end else if (req.op == FAG_OP_WRITE && is_lock_byte && any_lock) begin
          cause = `FAG_CAUSE_LOCKBYTE;
        end else if (tgt_locked && !exec_locked) begin
          fault = 1'b1;
          cause = `FAG_CAUSE_LOCKED;
        end else if (!modify) begin
          allow = 1'b1;
        end else if (!st_reg.ctl[`FAG_CTL_WE_BIT]) begin
          cause = `FAG_CAUSE_ENABLE;
        end else if (req.op == FAG_OP_ERASE && !st_reg.ctl[`FAG_CTL_EE_BIT]) begin
          cause = `FAG_CAUSE_ENABLE;
        end else if (st_reg.key != FAG_KEY_ARMED) begin
          cause = `FAG_CAUSE_KEY;
        end else begin
          allow = 1'b1;
        end
        // Each modification attempt outside a key write cycle consumes the key; an unarmed attempt kills it
        if (modify && !key_hit) begin
          st_next.key = (st_reg.key == FAG_KEY_ARMED) ? FAG_KEY_IDLE : FAG_KEY_DEAD;
        end
      end

      st_next.cmd.valid = allow;
      st_next.cmd.op = req.op;
      st_next.cmd.wdata = req.wdata;
      st_next.cmd.addr = (req.op == FAG_OP_ERASE) ? {page, `FAG_PAGE_OFS_ZERO} : req.addr;
      st_next.denied = !allow;
      st_next.flash_error = fault;
      if (!allow) begin
        st_next.cause = cause;
        st_next.deny_count = st_reg.deny_count + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{ctl: `FAG_CTL_RESET, key: FAG_KEY_IDLE, cmd: '0, denied: 1'b0, flash_error: 1'b0,
                  cause: `FAG_CAUSE_NONE, deny_count: 8'h00, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign flash_cmd = st_reg.cmd;
  assign req_denied = st_reg.denied;
  assign flash_error_reset = st_reg.flash_error;
  assign xdata_to_flash = st_reg.ctl[`FAG_CTL_WE_BIT];

endmodule

// ---- fag_guard_properties.sv ----
// Concurrent checks on the flash access guard ports
`timescale 1ns/1ns
`include "fag_defs.svh"
module fag_guard_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Requests and decisions
  input wire fag_pkg::fag_req_t req,
  input wire logic [7:0] lock_byte,
  input wire fag_pkg::fag_cmd_t flash_cmd,
  input wire logic req_denied,
  input wire logic flash_error_reset,
  input wire logic xdata_to_flash
);
  import fag_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic fw = req.valid && !req.from_debug;
  sequence s_refused; ##1 req_denied; endsequence
  sequence s_granted; ##1 flash_cmd.valid; endsequence
  property p_one; req.valid |=> flash_cmd.valid ^ req_denied; endproperty
  a_one: assert property (p_one) else $error("request not answered once");
  property p_quiet; !req.valid |=> !flash_cmd.valid && !req_denied; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_rst; flash_error_reset |-> req_denied; endproperty
  a_rst: assert property (p_rst) else $error("error reset on granted access");
  property p_resv; req.valid && req.op != FAG_OP_ERASE_ALL && req.addr[12:9] == `FAG_RESERVED_PAGE |-> s_refused;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved area reached");
  property p_we; fw && req.op != FAG_OP_READ && !xdata_to_flash |-> s_refused; endproperty
  a_we: assert property (p_we) else $error("modify without write enable");
  property p_lkers; fw && req.op == FAG_OP_ERASE && req.addr[12:9] == `FAG_LOCK_PAGE |=> req_denied && flash_error_reset;
  endproperty
  a_lkers: assert property (p_lkers) else $error("lock page erased by firmware");
  property p_lkrd; req.valid && req.from_debug && req.op != FAG_OP_ERASE_ALL && req.addr == `FAG_LOCK_ADDR &&
    lock_byte != `FAG_LOCK_ERASED
    |-> s_refused; endproperty
  a_lkrd: assert property (p_lkrd) else $error("lock byte open on debug port");
  property p_all; req.valid && req.from_debug && req.op == FAG_OP_ERASE_ALL |-> s_granted; endproperty
  a_all: assert property (p_all) else $error("whole erase refused");
  property p_algn; flash_cmd.valid && flash_cmd.op == FAG_OP_ERASE |-> flash_cmd.addr[8:0] == `FAG_PAGE_OFS_ZERO;
  endproperty
  a_algn: assert property (p_algn) else $error("erase not page aligned");
  property p_fwlk; fw && req.op == FAG_OP_READ && req.addr == `FAG_LOCK_ADDR |-> s_granted; endproperty
  a_fwlk: assert property (p_fwlk) else $error("firmware lock byte read refused");
endmodule
bind fag_guard fag_guard_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
  .lock_byte(lock_byte), .flash_cmd(flash_cmd), .req_denied(req_denied), .flash_error_reset(flash_error_reset),
  .xdata_to_flash(xdata_to_flash));

// ---- fag_pkg.sv ----
// Types shared by the flash access guard and its surroundings
package fag_pkg;

  typedef enum logic [1:0] {
    FAG_OP_READ = 2'h0,
    FAG_OP_WRITE = 2'h1,
    FAG_OP_ERASE = 2'h2,
    FAG_OP_ERASE_ALL = 2'h3
  } fag_op_t;

  // Gray order along idle -> half -> armed; dead is terminal until reset
  typedef enum logic [1:0] {
    FAG_KEY_IDLE = 2'h0,
    FAG_KEY_HALF = 2'h1,
    FAG_KEY_ARMED = 2'h3,
    FAG_KEY_DEAD = 2'h2
  } fag_key_t;

  typedef struct packed {
    logic valid;
    logic from_debug;
    fag_op_t op;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [12:0] exec_addr;
  } fag_req_t;

  typedef struct packed {
    logic valid;
    fag_op_t op;
    logic [12:0] addr;
    logic [7:0] wdata;
  } fag_cmd_t;

  typedef struct packed {
    logic [1:0] ctl;
    fag_key_t key;
    fag_cmd_t cmd;
    logic denied;
    logic flash_error;
    logic [2:0] cause;
    logic [7:0] deny_count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fag_state_t;

endpackage

// ---- flash_access_security_guard_test.sv ----
// Self-checking bench for the flash access guard
`timescale 1ns/1ns
`include "fag_defs.svh"
module flash_access_security_guard_test;
  import fag_pkg::*;
  typedef struct packed {logic d; fag_op_t op; logic [12:0] a; logic [7:0] w; logic [12:0] x;
    logic [1:0] c; logic g; logic [1:0] r;} fag_row_t;
  localparam fag_op_t rd = FAG_OP_READ, wr = FAG_OP_WRITE, er = FAG_OP_ERASE, ea = FAG_OP_ERASE_ALL;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  fag_req_t req = '0;
  fag_cmd_t flash_cmd;
  logic [7:0] lock_byte;
  logic req_denied, flash_error_reset, xdata_to_flash;
  int err_total = 0, comparisons = 0;
  // Fields: debug, op, addr, data, exec, control, granted, error reset (2 = not checked)
  fag_row_t rows [20] = '{'{1,rd,'h100,0,0,0,1,0}, '{0,wr,'h100,0,'h400,0,0,0},
    '{0,er,'h100,0,'h400,1,0,0}, '{0,er,'h100,0,'h400,3,1,0},
    '{0,wr,'h1E00,0,'h400,1,0,1}, '{1,rd,'h1E00,0,0,0,0,2},
    '{0,er,'h1C00,0,'h400,3,0,1}, '{1,wr,'h1DFF,'hFE,0,0,1,0},
    '{1,rd,'h100,0,0,0,0,2}, '{1,rd,'h1DFF,0,0,0,0,2},
    '{1,wr,'h1DFF,0,0,0,0,2}, '{0,rd,'h100,0,'h400,0,0,1},
    '{0,wr,'h100,0,0,1,1,0}, '{0,rd,'h1DFF,0,'h400,0,1,0},
    '{0,wr,'h1DFF,'hFF,0,1,0,2}, '{0,ea,0,0,0,3,0,0},
    '{1,ea,0,0,0,0,1,0}, '{1,rd,'h100,0,0,0,1,0},
    '{1,wr,'h1DFF,'h7F,0,0,1,0}, '{1,wr,'h600,0,0,0,0,2}};
  fag_guard dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .lock_byte(lock_byte), .flash_cmd(flash_cmd), .req_denied(req_denied),
    .flash_error_reset(flash_error_reset), .xdata_to_flash(xdata_to_flash));
  fag_flash_model flash (.pclk(pclk), .flash_cmd(flash_cmd), .lock_byte(lock_byte));
  always #20 pclk = ~pclk;
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task keys(input logic [7:0] k);
    apb(1, `FAG_OFS_KEY, `FAG_KEY_FIRST);
    apb(1, `FAG_OFS_KEY, k);
  endtask
  task send(input fag_row_t w);
    @(posedge pclk);
    req <= '{1'b1, w.d, w.op, w.a, w.w, w.x};
    @(posedge pclk);
    req.valid <= 1'b0;
    @(negedge pclk);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    results;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `FAG_OFS_CONTROL, 0);
    chk("control", r, `FAG_CTL_RESET);
    apb(0, `FAG_OFS_KEY, 0);
    chk("key state", r, FAG_KEY_IDLE);
    apb(0, 12'h010, 0);
    chk("unmapped data", r, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, `FAG_OFS_CONTROL, rows[i].c);
      if (!rows[i].d && rows[i].op != rd) keys(`FAG_KEY_SECOND);
      send(rows[i]);
      chk("granted", flash_cmd.valid, rows[i].g);
      chk("refused", req_denied, !rows[i].g);
      if (rows[i].r != 2) chk("error reset", flash_error_reset, rows[i].r[0]);
      $display("row %0d done", i);
    end
    chk("steering", xdata_to_flash, 0);
    apb(1, `FAG_OFS_CONTROL, 1);
    // The control bit lands at the access edge; look once it has settled
    @(negedge pclk);
    chk("steering", xdata_to_flash, 1);
    keys(8'h00);
    keys(`FAG_KEY_SECOND);
    apb(0, `FAG_OFS_KEY, 0);
    chk("key state", r, FAG_KEY_DEAD);
    send('{0, wr, 'h600, 0, 0, 1, 0, 0});
    chk("refused", {req_denied, flash_cmd.valid, flash_error_reset}, 3'b100);
    chk("command address", flash_cmd.addr, 13'h0600);
    apb(0, `FAG_OFS_LOCK, 0);
    chk("lock register", r, 32'h0000007F);
    // Thirteen refusals so far, the last one for a dead key
    apb(0, `FAG_OFS_STATUS, 0);
    chk("status", r, {21'h0, `FAG_CAUSE_KEY, 8'h0D});
    $display("key test done");
    results;
  end
endmodule
